// *** io_space_pkg.sv ***
// constants and types shared by the low i/o space decoder
`default_nettype none

package io_space_pkg;

  // address space layout
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20; // data alias of i/o addr 0
  localparam logic [7:0] IO_DATA_END    = 8'h5f; // last data alias of i/o
  localparam logic [7:0] EXT_FIRST      = 8'h60; // first extended address
  localparam logic [7:0] EXT_LAST       = 8'hff; // last extended address
  localparam logic [7:0] SHORT_IO_LAST  = 8'h3f; // 64 short i/o locations
  localparam logic [7:0] BIT_IO_LAST    = 8'h1f; // last bit-addressable reg

  // port register offsets (i/o addresses)
  localparam logic [7:0] OFF_PORT_A_INPUT     = 8'h00;
  localparam logic [7:0] OFF_PORT_A_DIRECTION = 8'h01;
  localparam logic [7:0] OFF_PORT_A_OUTPUT    = 8'h02;
  localparam logic [7:0] OFF_PORT_B_INPUT     = 8'h03;
  localparam logic [7:0] OFF_PORT_B_DIRECTION = 8'h04;
  localparam logic [7:0] OFF_PORT_B_OUTPUT    = 8'h05;
  localparam logic [7:0] OFF_PORT_C_INPUT     = 8'h06;
  localparam logic [7:0] OFF_PORT_C_DIRECTION = 8'h07;
  localparam logic [7:0] OFF_PORT_C_OUTPUT    = 8'h08;
  localparam logic [7:0] OFF_PORT_D_INPUT     = 8'h09;
  localparam logic [7:0] OFF_PORT_D_DIRECTION = 8'h0a;
  localparam logic [7:0] OFF_PORT_D_OUTPUT    = 8'h0b;

  // event flag register offsets
  localparam logic [7:0] OFF_TIMER0_EVENT_FLAGS     = 8'h15;
  localparam logic [7:0] OFF_TIMER1_EVENT_FLAGS     = 8'h16;
  localparam logic [7:0] OFF_TIMER2_EVENT_FLAGS     = 8'h17;
  localparam logic [7:0] OFF_PIN_CHANGE_EVENT_FLAGS = 8'h1b;

  // implemented flag bits, all others reserved
  localparam logic [7:0] TIMER0_FLAG_MASK     = 8'h07;
  localparam logic [7:0] TIMER1_FLAG_MASK     = 8'h27;
  localparam logic [7:0] TIMER2_FLAG_MASK     = 8'h07;
  localparam logic [7:0] PIN_CHANGE_FLAG_MASK = 8'h0f;

  // values after reset
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // access kinds issued by the core
  typedef enum logic [2:0] {
    OP_IO_READ            = 3'h0, // short i/o read
    OP_IO_WRITE           = 3'h1, // short i/o write
    OP_DATA_LOAD          = 3'h2, // indirect, direct or displacement load
    OP_DATA_STORE         = 3'h3, // indirect, direct or displacement store
    OP_BIT_SET            = 3'h4, // bit_set_op
    OP_BIT_CLEAR          = 3'h5, // bit_clear_op
    OP_SKIP_IF_BIT_SET    = 3'h6, // skip_if_bit_set_op
    OP_SKIP_IF_BIT_CLEAR  = 3'h7  // skip_if_bit_clear_op
  } acc_op_t;

endpackage : io_space_pkg

`default_nettype wire

// *** io_space_decoder.sv ***
// low i/o space decoder with port and event flag registers
//
// What this block does
// R1 - short i/o ops address locations 0x00 to 0x3f
// R2 - data space sees i/o registers plus 0x20
// R3 - short i/o path never reaches beyond 64
// R4 - extended 0x60-0xff only via data loads/stores
// R5 - bit set/clear only on 0x00 to 0x1f
// R6 - skip tests read any bit there
// R7 - flags clear on written one, keep on zero
// R8 - bit set/clear rewrite whole register, clearing flags
// R9 - core never writes reserved addresses; bench bit-clears reserved 0x1f
// R10 - core writes zero to reserved bits
// R11 - port d output at 0x0b, bit n pin n
// R12 - port a output at 0x02, bit n pin n
// R13 - reserved reads zero, reserved writes ignored
`default_nettype none

module io_space_decoder
  import io_space_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       acc_valid,
  input  wire acc_op_t    acc_op,
  input  wire logic [7:0] acc_addr,
  input  wire logic [7:0] acc_wdata,
  input  wire logic [2:0] acc_bit,
  input  wire logic [7:0] port_a_in,
  input  wire logic [7:0] port_b_in,
  input  wire logic [7:0] port_c_in,
  input  wire logic [7:0] port_d_in,
  input  wire logic [7:0] timer0_event,
  input  wire logic [7:0] timer1_event,
  input  wire logic [7:0] timer2_event,
  input  wire logic [7:0] pin_change_event,
  output logic      [7:0] rd_data_q,
  output logic            rd_valid_q,
  output logic            skip_q,
  output logic            acc_err_q,
  output logic            ext_sel_q,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe,
  output logic      [7:0] port_b_out,
  output logic      [7:0] port_b_oe,
  output logic      [7:0] port_c_out,
  output logic      [7:0] port_c_oe,
  output logic      [7:0] port_d_out,
  output logic      [7:0] port_d_oe,
  output logic      [7:0] timer0_flags,
  output logic      [7:0] timer1_flags,
  output logic      [7:0] timer2_flags,
  output logic      [7:0] pin_change_flags
);

  // per-port and per-flag-register offset and mask tables
  localparam logic [7:0] IN_OFF [4] = '{OFF_PORT_A_INPUT, OFF_PORT_B_INPUT,
                                        OFF_PORT_C_INPUT, OFF_PORT_D_INPUT};
  localparam logic [7:0] DIR_OFF [4] = '{OFF_PORT_A_DIRECTION,
                                         OFF_PORT_B_DIRECTION,
                                         OFF_PORT_C_DIRECTION,
                                         OFF_PORT_D_DIRECTION};
  localparam logic [7:0] OUT_OFF [4] = '{OFF_PORT_A_OUTPUT, OFF_PORT_B_OUTPUT,
                                         OFF_PORT_C_OUTPUT, OFF_PORT_D_OUTPUT};
  localparam logic [7:0] FLAG_OFF [4] = '{OFF_TIMER0_EVENT_FLAGS,
                                          OFF_TIMER1_EVENT_FLAGS,
                                          OFF_TIMER2_EVENT_FLAGS,
                                          OFF_PIN_CHANGE_EVENT_FLAGS};
  localparam logic [7:0] FLAG_MASK [4] = '{TIMER0_FLAG_MASK,
                                           TIMER1_FLAG_MASK,
                                           TIMER2_FLAG_MASK,
                                           PIN_CHANGE_FLAG_MASK};

  logic [7:0] sync1_q [4];   // first pin sampling stage
  logic [7:0] sync2_q [4];   // second pin sampling stage
  logic [7:0] sync3_q [4];   // third pin sampling stage
  logic [7:0] pin_q   [4];   // filtered pin levels
  logic [7:0] dir_q   [4];   // direction registers
  logic [7:0] out_q   [4];   // output registers
  logic [7:0] flag_q  [4];   // sticky event flags
  logic [7:0] evt     [4];   // event pulses from peripherals
  logic [7:0] pin_raw [4];   // unsynchronised pins

  logic       is_short;      // short i/o instruction
  logic       is_data;       // data-space load or store
  logic       is_bitop;      // bit set, clear or test
  logic       in_io;         // access lands in the low i/o space
  logic       acc_bad;       // access refused
  logic       is_ext;        // access belongs to the extended space
  logic       is_write;      // access modifies a register
  logic [7:0] io_addr;       // resolved i/o address
  logic [7:0] cur_val;       // current register contents
  logic [7:0] bit_mask;      // one-hot selected bit
  logic [7:0] wr_val_d;      // value written back
  logic       wr_en;         // a legal write this cycle

  assign pin_raw = '{port_a_in, port_b_in, port_c_in, port_d_in};
  assign evt     = '{timer0_event, timer1_event, timer2_event,
                     pin_change_event};

  // read one i/o location; unmapped addresses read zero
  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input logic [7:0] pins [4],
                                          input logic [7:0] dirs [4],
                                          input logic [7:0] outs [4],
                                          input logic [7:0] flags [4]);
    logic [7:0] v;
    v = 8'h00;                                              // R13
    for (int i = 0; i < 4; i++) begin
      if (a == IN_OFF[i]) begin
        v = pins[i];
      end
      if (a == DIR_OFF[i]) begin
        v = dirs[i];
      end
      if (a == OUT_OFF[i]) begin
        v = outs[i];
      end
      if (a == FLAG_OFF[i]) begin
        v = flags[i] & FLAG_MASK[i];                        // R13
      end
    end
    return v;
  endfunction : read_reg

  // classify the access and resolve its i/o address
  always_comb begin
    is_short = (acc_op == OP_IO_READ) || (acc_op == OP_IO_WRITE);
    is_data  = (acc_op == OP_DATA_LOAD) || (acc_op == OP_DATA_STORE);
    is_bitop = !is_short && !is_data;
    // short path carries only a 6-bit field
    io_addr  = {2'b00, acc_addr[5:0]};                      // R1 R3
    in_io    = 1'b0;
    acc_bad  = 1'b0;
    is_ext   = 1'b0;
    if (is_short) begin
      in_io = (io_addr <= SHORT_IO_LAST);                   // R1
    end else if (is_data) begin
      // data alias sits 0x20 above the i/o address
      io_addr = acc_addr - IO_DATA_OFFSET;                  // R2
      in_io   = (acc_addr >= IO_DATA_OFFSET) &&
                (acc_addr <= IO_DATA_END);                  // R2
      is_ext  = (acc_addr >= EXT_FIRST) &&
                (acc_addr <= EXT_LAST);                     // R4
      acc_bad = (acc_addr < IO_DATA_OFFSET);
    end else begin
      // bit ops refused above the bit-addressable range
      io_addr = acc_addr;
      in_io   = (acc_addr <= BIT_IO_LAST);                  // R5
      acc_bad = !in_io;                                     // R5
    end
  end

  // current value and write-back value for every access kind
  always_comb begin
    cur_val  = read_reg(io_addr, pin_q, dir_q, out_q, flag_q);
    bit_mask = 8'h01 << acc_bit;                            // R6
    is_write = 1'b0;
    wr_val_d = acc_wdata;
    unique case (acc_op)
      OP_IO_WRITE, OP_DATA_STORE: begin
        is_write = 1'b1;
      end
      OP_BIT_SET: begin
        // whole register rewritten; set flags are written back as ones and so clear
        is_write = 1'b1;
        wr_val_d = cur_val | bit_mask;                      // R8
      end
      OP_BIT_CLEAR: begin
        is_write = 1'b1;
        wr_val_d = cur_val & ~bit_mask;                     // R8
      end
      OP_IO_READ, OP_DATA_LOAD,
      OP_SKIP_IF_BIT_SET, OP_SKIP_IF_BIT_CLEAR: begin
        is_write = 1'b0;
      end
    endcase
    wr_en = acc_valid && in_io && !acc_bad && is_write;
  end

  // three-stage pin sampling; a bit moves once stages two and three agree
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        sync1_q[i] <= PORT_RESET;
        sync2_q[i] <= PORT_RESET;
        sync3_q[i] <= PORT_RESET;
        pin_q[i]   <= PORT_RESET;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
        pin_q[i]   <= (sync2_q[i] & ~(sync2_q[i] ^ sync3_q[i])) |
                      (pin_q[i] & (sync2_q[i] ^ sync3_q[i]));
      end
    end
  end

  // direction and output registers; input registers ignore writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        dir_q[i] <= PORT_RESET;
        out_q[i] <= PORT_RESET;
      end
    end else if (wr_en) begin
      for (int i = 0; i < 4; i++) begin
        if (io_addr == DIR_OFF[i]) begin
          dir_q[i] <= wr_val_d;
        end
        // port a at 0x02 and port d at 0x0b, bit n drives pin n
        if (io_addr == OUT_OFF[i]) begin
          out_q[i] <= wr_val_d;                             // R11 R12
        end
      end
    end
  end

  // event flags: set by pulses, cleared by written ones, set wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        flag_q[i] <= FLAG_RESET;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_en && io_addr == FLAG_OFF[i]) begin
          flag_q[i] <= ((flag_q[i] & ~wr_val_d) | evt[i]) &
                       FLAG_MASK[i];                        // R7
        end else begin
          flag_q[i] <= (flag_q[i] | evt[i]) & FLAG_MASK[i];
        end
      end
    end
  end

  // answer to the core, one cycle after the access
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
      skip_q     <= 1'b0;
      acc_err_q  <= 1'b0;
      ext_sel_q  <= 1'b0;
    end else begin
      rd_valid_q <= acc_valid && !is_write && !acc_bad;
      acc_err_q  <= acc_valid && acc_bad;                   // R5
      ext_sel_q  <= acc_valid && is_ext;                    // R4
      rd_data_q  <= (acc_valid && in_io && !acc_bad) ? cur_val : 8'h00;
      // skip result tests the selected bit
      skip_q     <= acc_valid && in_io && !acc_bad &&
                    (((acc_op == OP_SKIP_IF_BIT_SET) &&
                      ((cur_val & bit_mask) != 8'h00)) ||
                     ((acc_op == OP_SKIP_IF_BIT_CLEAR) &&
                      ((cur_val & bit_mask) == 8'h00)));    // R6
    end
  end

  // pin drivers and flags straight from the registers
  assign port_a_out       = out_q[0];
  assign port_a_oe        = dir_q[0];
  assign port_b_out       = out_q[1];
  assign port_b_oe        = dir_q[1];
  assign port_c_out       = out_q[2];
  assign port_c_oe        = dir_q[2];
  assign port_d_out       = out_q[3];
  assign port_d_oe        = dir_q[3];
  assign timer0_flags     = flag_q[0];
  assign timer1_flags     = flag_q[1];
  assign timer2_flags     = flag_q[2];
  assign pin_change_flags = flag_q[3];

  // checks on the decoder's own behaviour
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_short_write_port_d;
    logic [7:0] d;
    (acc_valid && acc_op == OP_IO_WRITE && acc_addr == 8'h0b, d = acc_wdata)
      |=> (port_d_out == d);
  endproperty
  a_short_write_port_d : assert property (p_short_write_port_d) // R11
    else $error("short write to 0x0b did not reach port d output");

  property p_short_write_port_a;
    logic [7:0] d;
    (acc_valid && acc_op == OP_IO_WRITE && acc_addr == 8'h02, d = acc_wdata)
      |=> (port_a_out == d) ##1 (port_a_out == d || $past(acc_valid));
  endproperty
  a_short_write_port_a : assert property (p_short_write_port_a) // R12
    else $error("short write to 0x02 did not reach port a output");

  property p_data_alias;
    logic [7:0] d;
    (acc_valid && acc_op == OP_DATA_STORE && acc_addr == 8'h2b,
     d = acc_wdata) |=> (port_d_out == d);
  endproperty
  a_data_alias : assert property (p_data_alias) // R2
    else $error("data store at 0x2b did not reach port d output");

  property p_short_wraps;
    logic [7:0] d;
    (acc_valid && acc_op == OP_IO_WRITE && acc_addr == 8'h42,
     d = acc_wdata) |=> (port_a_out == d) && !ext_sel_q;
  endproperty
  a_short_wraps : assert property (p_short_wraps) // R3
    else $error("short write escaped the 64-location space");

  property p_ext_only_data;
    acc_valid |=> (ext_sel_q == ($past(is_data) &&
                                 $past(acc_addr) >= 8'h60));
  endproperty
  a_ext_only_data : assert property (p_ext_only_data) // R4
    else $error("extended select does not match a data access above 0x5f");

  property p_bitop_range;
    (acc_valid && is_bitop && acc_addr > 8'h1f)
      |=> acc_err_q && !rd_valid_q && $stable(port_a_out) &&
          $stable(port_d_out);
  endproperty
  a_bitop_range : assert property (p_bitop_range) // R5
    else $error("bit op above 0x1f was not refused");

  property p_skip_bit;
    (acc_valid && acc_op == OP_SKIP_IF_BIT_SET && acc_addr == 8'h0a)
      |=> (skip_q == $past(dir_q[3][acc_bit])) && rd_valid_q;
  endproperty
  a_skip_bit : assert property (p_skip_bit) // R6
    else $error("skip test did not follow the selected bit");

  property p_w1c_keep_zero;
    (acc_valid && acc_op == OP_IO_WRITE && acc_addr == 8'h16 &&
     timer1_event == 8'h00)
      |=> (timer1_flags == ($past(timer1_flags) & ~$past(acc_wdata)));
  endproperty
  a_w1c_keep_zero : assert property (p_w1c_keep_zero) // R7
    else $error("timer1 flags did not follow write-one-to-clear");

  property p_bitset_clears_all;
    (acc_valid && acc_op == OP_BIT_SET && acc_addr == 8'h1b &&
     pin_change_event == 8'h00) |=> (pin_change_flags == 8'h00);
  endproperty
  a_bitset_clears_all : assert property (p_bitset_clears_all) // R8
    else $error("bit set on pin change flags left a flag standing");

  property p_reserved_quiet;
    (acc_valid && acc_op == OP_IO_READ && acc_addr == 8'h0c)
      |=> rd_valid_q && rd_data_q == 8'h00;
  endproperty
  a_reserved_quiet : assert property (p_reserved_quiet) // R13
    else $error("reserved address did not read zero");

endmodule : io_space_decoder

`default_nettype wire

// *** core_model.sv ***
// processor core model that issues i/o, data-space and bit accesses
`default_nettype none

module core_model
  import io_space_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] rd_data_q,
  input  wire logic       rd_valid_q,
  input  wire logic       skip_q,
  input  wire logic       acc_err_q,
  input  wire logic       ext_sel_q,
  output var  logic       acc_valid,
  output var  acc_op_t    acc_op,
  output var  logic [7:0] acc_addr,
  output var  logic [7:0] acc_wdata,
  output var  logic [2:0] acc_bit
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    acc_valid = 1'b0;
    acc_op    = OP_IO_READ;
    acc_addr  = 8'h00;
    acc_wdata = 8'h00;
    acc_bit   = 3'h0;
  end

  // one access: drive after an edge, hold to the taking edge, then sample
  // the answer and scramble the released address, data and bit lines so stale values never help
  task automatic access(input acc_op_t op, input logic [7:0] addr,
                        input logic [7:0] wdata, input logic [2:0] bit_idx,
                        output logic [7:0] rdata, output logic [3:0] resp);
    @(posedge clk_sys);
    #1;
    acc_valid = 1'b1;
    acc_op    = op;
    acc_addr  = addr;
    acc_wdata = wdata;
    acc_bit   = bit_idx;
    @(posedge clk_sys);
    #1;
    rdata     = rd_data_q;
    resp      = {rd_valid_q, skip_q, acc_err_q, ext_sel_q};
    acc_valid = 1'b0;
    acc_addr  = ~addr;
    acc_wdata = ~wdata;
    acc_bit   = ~bit_idx;
  endtask : access

endmodule : core_model

`default_nettype wire

// *** io_space_decoder_tb.sv ***
// self-checking bench for the low i/o space decoder
`default_nettype none

`define CHK(nm, ex, got) begin \
  n_compared++; \
  if ((got) !== (ex)) begin \
    n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); \
  end \
end

module io_space_decoder_tb
  import io_space_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // one access with its expected answer {valid, skip, err, ext}
  typedef struct {
    acc_op_t    op;
    logic [7:0] addr;
    logic [7:0] wd;
    logic [2:0] bi;
    logic [7:0] rd;
    logic [3:0] rsp;
  } row_t;

  logic clk_sys, reset_n, acc_valid;
  acc_op_t acc_op;
  logic [7:0] acc_addr, acc_wdata, rd_data_q, rd;
  logic [2:0] acc_bit;
  logic [7:0] pa_in, pb_in, pc_in, pd_in, t0_ev, t1_ev, t2_ev, pc_ev;
  logic rd_valid_q, skip_q, acc_err_q, ext_sel_q;
  logic [7:0] pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe, pd_out, pd_oe;
  logic [7:0] t0_fl, t1_fl, t2_fl, pc_fl;
  logic [3:0] rsp;
  int n_mismatch = 0;
  int n_compared = 0;

  // ordinary accesses in order; state carries from row to row
  row_t rows [35] = '{
    '{OP_IO_WRITE, 8'h0b, 8'ha5, 3'h0, 8'h00, 4'h0},
    '{OP_IO_READ, 8'h0b, 8'h00, 3'h0, 8'ha5, 4'h8},
    '{OP_DATA_LOAD, 8'h2b, 8'h00, 3'h0, 8'ha5, 4'h8},
    '{OP_DATA_STORE, 8'h22, 8'h3c, 3'h0, 8'h00, 4'h0},
    '{OP_IO_READ, 8'h42, 8'h00, 3'h0, 8'h3c, 4'h8},
    '{OP_DATA_STORE, 8'h21, 8'hf0, 3'h0, 8'h00, 4'h0},
    '{OP_IO_WRITE, 8'h0a, 8'h0f, 3'h0, 8'h00, 4'h0},
    '{OP_IO_READ, 8'h01, 8'h00, 3'h0, 8'hf0, 4'h8},
    '{OP_IO_WRITE, 8'h02, 8'h66, 3'h0, 8'h00, 4'h0},
    '{OP_IO_WRITE, 8'h42, 8'hc3, 3'h0, 8'h00, 4'h0},
    '{OP_IO_WRITE, 8'h05, 8'h96, 3'h0, 8'h00, 4'h0},
    '{OP_DATA_STORE, 8'h24, 8'h69, 3'h0, 8'h00, 4'h0},
    '{OP_IO_WRITE, 8'h08, 8'he1, 3'h0, 8'h00, 4'h0},
    '{OP_DATA_STORE, 8'h27, 8'h1e, 3'h0, 8'h00, 4'h0},
    '{OP_IO_READ, 8'h0c, 8'h00, 3'h0, 8'h00, 4'h8},
    '{OP_IO_READ, 8'h30, 8'h00, 3'h0, 8'h00, 4'h8},
    '{OP_IO_WRITE, 8'h00, 8'hff, 3'h0, 8'h00, 4'h0},
    '{OP_DATA_LOAD, 8'h20, 8'h00, 3'h0, 8'h5a, 4'h8},
    '{OP_DATA_LOAD, 8'h23, 8'h00, 3'h0, 8'h81, 4'h8},
    '{OP_IO_READ, 8'h06, 8'h00, 3'h0, 8'hc3, 4'h8},
    '{OP_DATA_LOAD, 8'h29, 8'h00, 3'h0, 8'h3c, 4'h8},
    '{OP_DATA_LOAD, 8'h60, 8'h00, 3'h0, 8'h00, 4'h9},
    '{OP_DATA_STORE, 8'hff, 8'h11, 3'h0, 8'h00, 4'h1},
    '{OP_IO_READ, 8'h60, 8'h00, 3'h0, 8'h00, 4'h8},
    '{OP_DATA_LOAD, 8'h1f, 8'h00, 3'h0, 8'h00, 4'h2},
    '{OP_BIT_SET, 8'h0b, 8'h00, 3'h6, 8'h00, 4'h0},
    '{OP_BIT_CLEAR, 8'h0b, 8'h00, 3'h0, 8'h00, 4'h0},
    '{OP_IO_READ, 8'h0b, 8'h00, 3'h0, 8'he4, 4'h8},
    '{OP_DATA_STORE, 8'h2b, 8'h4e, 3'h0, 8'h00, 4'h0},
    '{OP_BIT_SET, 8'h20, 8'h00, 3'h0, 8'h00, 4'h2},
    '{OP_BIT_CLEAR, 8'h1f, 8'h00, 3'h0, 8'h00, 4'h0},
    '{OP_SKIP_IF_BIT_SET, 8'h0a, 8'h00, 3'h3, 8'h00, 4'hc},
    '{OP_SKIP_IF_BIT_SET, 8'h0a, 8'h00, 3'h4, 8'h00, 4'h8},
    '{OP_SKIP_IF_BIT_CLEAR, 8'h0a, 8'h00, 3'h4, 8'h00, 4'hc},
    '{OP_SKIP_IF_BIT_CLEAR, 8'h0a, 8'h00, 3'h0, 8'h00, 4'h8}
  };

  io_space_decoder u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .acc_valid(acc_valid),
    .acc_op(acc_op), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_bit(acc_bit), .port_a_in(pa_in), .port_b_in(pb_in),
    .port_c_in(pc_in), .port_d_in(pd_in), .timer0_event(t0_ev),
    .timer1_event(t1_ev), .timer2_event(t2_ev), .pin_change_event(pc_ev),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .skip_q(skip_q),
    .acc_err_q(acc_err_q), .ext_sel_q(ext_sel_q), .port_a_out(pa_out),
    .port_a_oe(pa_oe), .port_b_out(pb_out), .port_b_oe(pb_oe),
    .port_c_out(pc_out), .port_c_oe(pc_oe), .port_d_out(pd_out),
    .port_d_oe(pd_oe), .timer0_flags(t0_fl), .timer1_flags(t1_fl),
    .timer2_flags(t2_fl), .pin_change_flags(pc_fl)
  );

  core_model u_core (
    .clk_sys(clk_sys), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .skip_q(skip_q), .acc_err_q(acc_err_q), .ext_sel_q(ext_sel_q),
    .acc_valid(acc_valid), .acc_op(acc_op), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_bit(acc_bit)
  );

  // free-running clock
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  // prints the counts and the verdict, then ends the run
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // shorthand for one access through the core model
  task automatic acc(input acc_op_t op, input logic [7:0] a,
                     input logic [7:0] wd, input logic [2:0] bi);
    u_core.access(op, a, wd, bi, rd, rsp);
  endtask : acc

  // cuts a hang short
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end

  // main sequence
  initial begin
    reset_n = 1'b0;
    {pa_in, pb_in, pc_in, pd_in} = 32'h5a81c33c;
    {t0_ev, t1_ev, t2_ev, pc_ev} = 32'h00000000;
    repeat (4) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    `CHK("port_d_out", 8'h00, pd_out)
    `CHK("timer1_flags", 8'h00, t1_fl)
    repeat (4) @(posedge clk_sys);
    foreach (rows[i]) begin
      acc(rows[i].op, rows[i].addr, rows[i].wd, rows[i].bi);
      `CHK("answer", rows[i].rsp, rsp)
      if (rsp[3] && rows[i].op < OP_BIT_SET) begin
        `CHK("rd_data", rows[i].rd, rd)
      end
    end
    `CHK("port_d_out", 8'h4e, pd_out)
    `CHK("port_a_out", 8'hc3, pa_out)
    `CHK("port_b_out", 8'h96, pb_out)
    `CHK("port_b_oe", 8'h69, pb_oe)
    `CHK("port_c_out", 8'he1, pc_out)
    `CHK("port_c_oe", 8'h1e, pc_oe)
    `CHK("port_a_oe", 8'hf0, pa_oe)
    `CHK("port_d_oe", 8'h0f, pd_oe)
    // every flag of every event register raised for one cycle
    @(posedge clk_sys);
    #1;
    {t0_ev, t1_ev, t2_ev, pc_ev} = 32'hffffffff;
    @(posedge clk_sys);
    #1;
    {t0_ev, t1_ev, t2_ev, pc_ev} = 32'h00000000;
    `CHK("flags", 32'h0727070f, {t0_fl, t1_fl, t2_fl, pc_fl})
    acc(OP_IO_WRITE, 8'h16, 8'h01, 3'h0);
    `CHK("timer1_flags", 8'h26, t1_fl)
    acc(OP_IO_WRITE, 8'h16, 8'h00, 3'h0);
    `CHK("timer1_flags", 8'h26, t1_fl)
    acc(OP_SKIP_IF_BIT_SET, 8'h17, 8'h00, 3'h2);
    `CHK("skip_flag", 4'hc, rsp)
    acc(OP_BIT_CLEAR, 8'h16, 8'h00, 3'h1);
    `CHK("timer1_flags", 8'h02, t1_fl)
    acc(OP_BIT_SET, 8'h1b, 8'h00, 3'h0);
    `CHK("pin_change_flags", 8'h00, pc_fl)
    acc(OP_DATA_STORE, 8'h35, 8'h05, 3'h0);
    `CHK("timer0_flags", 8'h02, t0_fl)
    // second reset in mid-run clears everything at once
    reset_n = 1'b0;
    #1;
    `CHK("port_d_out", 8'h00, pd_out)
    `CHK("timer2_flags", 8'h00, t2_fl)
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    acc(OP_IO_READ, 8'h02, 8'h00, 3'h0);
    `CHK("rd_data", 8'h00, rd)
    stop_test();
  end

endmodule : io_space_decoder_tb

`default_nettype wire
